// >>> cpc_clock_gen.sv
`timescale 1ns/100ps
`default_nettype none
// frame and bit clock generator for a master-mode audio port
module cpc_clock_gen
  import cpc_pkg::*;
#(
  parameter int RW = RATIO_W
) (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire logic          enable,
  input  wire logic [RW-1:0] ratio,
  output logic               frame_clock,
  output logic               bit_clock
);

  logic [RW-1:0] mcnt;       // master clocks into the frame
  logic [RW-1:0] bcnt;       // master clocks into the bit period
  logic [RW-1:0] bdiv;       // master clocks per bit clock
  logic [RW-1:0] half;       // master clocks per frame half
  logic          frame_end;  // last master clock of the frame
  logic          bit_end;    // last master clock of the bit period

  assign bdiv      = ratio >> BCLK_SHIFT;
  assign half      = ratio >> 1;
  // a ratio change mid-frame just wraps at the next limit crossing
  assign frame_end = (mcnt >= ratio - 1'b1);
  assign bit_end   = (bcnt >= bdiv - 1'b1) || frame_end;

  // counters idle at zero while the port is a slave
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mcnt <= '0;
      bcnt <= '0;
    end else if (!enable) begin
      mcnt <= '0;
      bcnt <= '0;
    end else begin
      mcnt <= frame_end ? '0 : mcnt + 1'b1;
      bcnt <= bit_end ? '0 : bcnt + 1'b1;
    end
  end

  // outputs from flops so the pins never glitch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame_clock <= 1'b0;
      bit_clock   <= 1'b0;
    end else begin
      frame_clock <= enable && (mcnt >= half);
      bit_clock   <= enable && (bcnt >= (bdiv >> 1));
    end
  end

endmodule // cpc_clock_gen
`default_nettype wire

// >>> cpc_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
// watches the control block outputs for gating and ordering slips
module cpc_ctrl_sva
  import cpc_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  input wire logic           clk_sys,
  input wire logic           resetn,
  input wire logic           dac_frame_clock_out,
  input wire logic           dac_frame_clock_oe,
  input wire logic           dac_bit_clock_out,
  input wire logic           dac_bit_clock_oe,
  input wire logic           adc_frame_clock_out,
  input wire logic           adc_frame_clock_oe,
  input wire logic           adc_bit_clock_out,
  input wire logic           dac_port_frame,
  input wire logic [NCH-1:0] dac_chan_power_down,
  input wire logic [NCH-1:0] dac_filter_hold,
  input wire logic [NCH-1:0] dac_filter_init,
  input wire logic           adc_power_down,
  input wire logic           adc_filter_init,
  input wire logic [1:0]     adc_port_format,
  input wire logic [1:0]     adc_word_length,
  input wire logic           adc_dsp_mode_b,
  input wire logic           adc_frame_invert,
  input wire logic           adc_sample_valid,
  input wire logic [31:0]    adc_port_word,
  input wire logic           adc_port_word_valid
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_dac_oe_pair: assert property (
    dac_frame_clock_oe == dac_bit_clock_oe) else $error("dac enables split");
  chk_dac_slave_quiet: assert property (
    !dac_frame_clock_oe |-> !dac_frame_clock_out && !dac_bit_clock_out)
    else $error("dac clocks run in slave mode");
  chk_port_follows: assert property (
    dac_frame_clock_oe && $past(dac_frame_clock_oe)
    |-> dac_port_frame == $past(dac_frame_clock_out))
    else $error("dac port frame not from generator");
  chk_hold_level: assert property (
    dac_filter_hold == dac_chan_power_down) else $error("hold differs");
  chk_dac_init: assert property (
    $fell(dac_chan_power_down[0]) |=> dac_filter_init[0] ##1 !dac_filter_init[0])
    else $error("dac filter init pulse wrong");
  chk_adc_init: assert property (
    $fell(adc_power_down) |=> adc_filter_init ##1 !adc_filter_init)
    else $error("adc filter init pulse wrong");
  chk_adc_slave_quiet: assert property (
    !adc_frame_clock_oe |-> !adc_frame_clock_out && !adc_bit_clock_out)
    else $error("adc clocks run in slave mode");
  chk_word_pad: assert property (
    adc_port_word_valid |-> $past(adc_sample_valid) && !$past(adc_power_down)
    && adc_port_word[7:0] == 8'h00) else $error("adc word bad");
  chk_dsp_select: assert property (
    adc_dsp_mode_b |-> adc_port_format == 2'h3 && !adc_frame_invert)
    else $error("dsp mode b outside dsp");
  chk_rj_length: assert property (
    adc_port_format == 2'h0 |-> adc_word_length != 2'h3)
    else $error("32 bit right justified");

  // main scenarios reached
  cover property ($fell(dac_chan_power_down[0]));
  cover property (adc_port_word_valid);
  cover property ($rose(adc_dsp_mode_b));
endmodule // cpc_ctrl_sva

bind cpc_power_if_ctrl cpc_ctrl_sva #(.NCH(NCH)) i_sva (.*);
`default_nettype wire

// >>> cpc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side: serial control writer and slave-mode port clocks
module cpc_host_model (
  input  wire logic clk_sys,
  output logic      ctl_clock,
  output logic      ctl_data,
  output logic      ctl_latch,
  output logic      frame_in,
  output logic      bit_in
);
  int cnt = 0;  // system clocks within a frame half
  initial begin
    ctl_clock = 1'b0;
    ctl_data  = 1'b0;
    ctl_latch = 1'b0;
    frame_in  = 1'b0;
    bit_in    = 1'b0;
  end
  // external source clocks the ports, 64 bit clocks a frame
  always @(posedge clk_sys) begin
    bit_in <= ~bit_in;
    cnt    <= (cnt + 1) % 64;
    if (cnt == 0) frame_in <= ~frame_in;
  end
  // each level held at least two cycles so the sampled edges are never missed
  task automatic write(input logic [6:0] a, input logic [8:0] d);
    logic [15:0] w;
    w = {a, d};
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_sys) ctl_data <= w[i];
      repeat (2) @(posedge clk_sys);
      ctl_clock <= 1'b1;
      repeat (2) @(posedge clk_sys);
      ctl_clock <= 1'b0;
    end
    @(posedge clk_sys) ctl_latch <= 1'b1;
    repeat (2) @(posedge clk_sys);
    ctl_latch <= 1'b0;
    ctl_data  <= ~ctl_data;  // idle data is not worth trusting
    repeat (3) @(posedge clk_sys);
  endtask
endmodule // cpc_host_model
`default_nettype wire

// >>> cpc_pkg.sv
`default_nettype none
package cpc_pkg;

  // register and serial word geometry
  localparam int REG_W    = 9;
  localparam int ADDR_W   = 7;
  localparam int FRAME_W  = 16;
  localparam int NUM_CH   = 3;
  localparam int RATIO_W  = 10;
  localparam int WORD_W   = 32;
  localparam int SAMPLE_W = 24;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL   = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_SELECT_A   = 7'h09;
  localparam logic [ADDR_W-1:0] ADDR_POWER    = 7'h0A;
  localparam logic [ADDR_W-1:0] ADDR_ADC_PORT = 7'h0B;
  localparam logic [ADDR_W-1:0] ADDR_ADC_CTRL = 7'h0C;

  // global de-emphasis / power register fields
  localparam int GLB_CHAN_SELECT_A_BIT = 1;
  localparam int GLB_ALL_DAC_POWER_DOWN_BIT   = 2;
  // per-channel de-emphasis field
  localparam int CHAN_SELECT_A_LSB     = 6;
  // power-down and dac port register fields
  localparam int ADC_DIS_BIT    = 0;
  localparam int DAC_DIS_LSB    = 1;
  localparam int MPD_BIT        = 4;
  localparam int DAC_MS_BIT     = 5;
  localparam int DAC_RATE_LSB   = 6;
  // adc port register fields
  localparam int FMT_LSB        = 0;
  localparam int WL_LSB         = 2;
  localparam int ADC_MS_BIT     = 4;
  localparam int ADC_RATE_LSB   = 5;
  // adc control register field
  localparam int ADC_LRP_BIT    = 4;

  // reset values
  localparam logic [2:0] RATE_RST   = 3'h2;
  localparam logic [2:0] CH_RST     = 3'h0;
  localparam logic [9:0] RATIO_RST  = 10'h100;

  // master clocks per frame for each rate code
  localparam logic [9:0] RATIO_128 = 10'h080;
  localparam logic [9:0] RATIO_192 = 10'h0C0;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_384 = 10'h180;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam logic [9:0] RATIO_768 = 10'h300;
  localparam logic [9:0] RATIO_NONE = 10'h000;

  // bit clocks per frame: bit clock runs at 64 fs
  localparam int BCLK_SHIFT = 6;

  // word masks keeping the top bits of a left-aligned word
  localparam logic [31:0] MASK_16 = 32'hFFFF0000;
  localparam logic [31:0] MASK_20 = 32'hFFFFF000;
  localparam logic [31:0] MASK_24 = 32'hFFFFFF00;
  localparam logic [31:0] MASK_32 = 32'hFFFFFFFF;
  localparam logic [7:0]  PAD_ZERO = 8'h00;

  typedef enum logic [1:0] {FMT_RIGHT, FMT_LEFT, FMT_I2S, FMT_DSP} cpc_fmt_e;
  typedef enum logic [1:0] {WL_16, WL_20, WL_24, WL_32} cpc_wl_e;

endpackage
`default_nettype wire

// >>> cpc_power_if_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module cpc_power_if_ctrl
  import cpc_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 ctl_clock,
  input  wire logic                 ctl_data,
  input  wire logic                 ctl_latch,
  input  wire logic                 dac_frame_clock_in,
  output logic                      dac_frame_clock_out,
  output logic                      dac_frame_clock_oe,
  input  wire logic                 dac_bit_clock_in,
  output logic                      dac_bit_clock_out,
  output logic                      dac_bit_clock_oe,
  input  wire logic                 adc_frame_clock_in,
  output logic                      adc_frame_clock_out,
  output logic                      adc_frame_clock_oe,
  input  wire logic                 adc_bit_clock_in,
  output logic                      adc_bit_clock_out,
  output logic                      adc_bit_clock_oe,
  output logic                      dac_port_frame,
  output logic                      dac_port_bit,
  output logic                      adc_port_frame,
  output logic                      adc_port_bit,
  output logic [NCH-1:0]            dac_chan_select_a_active,
  output logic [NCH-1:0]            dac_chan_power_down,
  output logic [NCH-1:0]            dac_filter_hold,
  output logic [NCH-1:0]            dac_filter_init,
  output logic                      adc_power_down,
  output logic                      adc_filter_hold,
  output logic                      adc_filter_init,
  output logic                      reference_power_down,
  output logic [1:0]                adc_port_format,
  output logic [1:0]                adc_word_length,
  output logic                      adc_dsp_mode_b,
  output logic                      adc_frame_invert,
  input  wire logic [SAMPLE_W-1:0]  adc_sample,
  input  wire logic                 adc_sample_valid,
  output logic [WORD_W-1:0]         adc_port_word,
  output logic                      adc_port_word_valid
);

  // ---------------- serial control port ----------------
  logic [FRAME_W-1:0] shift_word;     // last sixteen serial bits
  logic               ctl_clock_prev; // previous sample of shift clock
  logic               ctl_latch_prev; // previous sample of latch
  logic               shift_rise;     // shift clock rising
  logic               latch_rise;     // latch rising: commit word
  logic [ADDR_W-1:0]  wr_addr;        // address half of the word
  logic [REG_W-1:0]   wr_data;        // data half of the word
  logic               wr_global;      // write strobes per register
  logic               wr_chan_select_a;
  logic               wr_power;
  logic               wr_adc_port;
  logic               wr_adc_ctrl;

  assign shift_rise  = ctl_clock & ~ctl_clock_prev;
  assign latch_rise  = ctl_latch & ~ctl_latch_prev;
  assign wr_addr     = shift_word[FRAME_W-1 -: ADDR_W];
  assign wr_data     = shift_word[REG_W-1:0];
  assign wr_global   = latch_rise && (wr_addr == ADDR_GLOBAL);
  assign wr_chan_select_a   = latch_rise && (wr_addr == ADDR_CHAN_SELECT_A);
  assign wr_power    = latch_rise && (wr_addr == ADDR_POWER);
  assign wr_adc_port = latch_rise && (wr_addr == ADDR_ADC_PORT);
  assign wr_adc_ctrl = latch_rise && (wr_addr == ADDR_ADC_CTRL);

  // shifter: msb first, address then data; other addresses are ignored
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shift_word     <= '0;
      ctl_clock_prev <= 1'b0;
      ctl_latch_prev <= 1'b0;
    end else begin
      ctl_clock_prev <= ctl_clock;
      ctl_latch_prev <= ctl_latch;
      if (shift_rise) begin
        shift_word <= {shift_word[FRAME_W-2:0], ctl_data};
      end
    end
  end

  // ---------------- control registers ----------------
  logic              global_chan_select_a_enable;   // all-channel de-emphasis
  logic              all_dac_power_down;     // every dac off
  logic [NCH-1:0]    chan_select_a;          // per-channel de-emphasis
  logic              adc_disable;            // adc low power
  logic [NCH-1:0]    dac_chan_disable;       // per-channel dac off
  logic              master_power_down;      // references off
  logic              dac_port_master_select; // dac port master
  logic [2:0]        dac_clock_ratio;        // dac rate code
  cpc_fmt_e          adc_fmt;                // adc port format
  cpc_wl_e           adc_wl;                 // adc word length
  logic              adc_port_master_select; // adc port master
  logic [2:0]        adc_clock_ratio;        // adc rate code
  logic              adc_frame_polarity;     // adc frame polarity / dsp b

  // registers keep their contents through every power-down bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      global_chan_select_a_enable <= 1'b0;
      all_dac_power_down   <= 1'b0;
      chan_select_a        <= CH_RST;
      adc_disable          <= 1'b0;
      dac_chan_disable     <= CH_RST;
      master_power_down    <= 1'b0;
      dac_port_master_select <= 1'b0;
      dac_clock_ratio      <= RATE_RST;
      adc_fmt              <= FMT_RIGHT;
      adc_wl               <= WL_16;
      adc_port_master_select <= 1'b0;
      adc_clock_ratio      <= RATE_RST;
      adc_frame_polarity   <= 1'b0;
    end else begin
      if (wr_global) begin
        global_chan_select_a_enable <= wr_data[GLB_CHAN_SELECT_A_BIT];
        all_dac_power_down   <= wr_data[GLB_ALL_DAC_POWER_DOWN_BIT];
      end
      if (wr_chan_select_a) begin
        chan_select_a <= wr_data[CHAN_SELECT_A_LSB +: NCH];
      end
      if (wr_power) begin
        adc_disable            <= wr_data[ADC_DIS_BIT];
        dac_chan_disable       <= wr_data[DAC_DIS_LSB +: NCH];
        master_power_down      <= wr_data[MPD_BIT];
        dac_port_master_select <= wr_data[DAC_MS_BIT];
        dac_clock_ratio        <= wr_data[DAC_RATE_LSB +: 3];
      end
      if (wr_adc_port) begin
        adc_fmt                <= cpc_fmt_e'(wr_data[FMT_LSB +: 2]);
        adc_wl                 <= cpc_wl_e'(wr_data[WL_LSB +: 2]);
        adc_port_master_select <= wr_data[ADC_MS_BIT];
        adc_clock_ratio        <= wr_data[ADC_RATE_LSB +: 3];
      end
      if (wr_adc_ctrl) begin
        adc_frame_polarity <= wr_data[ADC_LRP_BIT];
      end
    end
  end

  // ---------------- de-emphasis and references ----------------
  // plain bitmask, so code 111 covers all three channels
  assign dac_chan_select_a_active = chan_select_a
                           | {NCH{global_chan_select_a_enable}};
  assign reference_power_down = master_power_down;

  // ---------------- power-down and filter reinitialisation ----------------
  logic [NCH-1:0] dac_off;      // channel held in low power
  logic [NCH-1:0] dac_off_prev; // previous cycle, for release edge
  logic           adc_off_prev;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_dac_ch
      // global power-down wins over the per-channel bit
      assign dac_off[ch] = all_dac_power_down
                         | dac_chan_disable[ch];

      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          dac_off_prev[ch]    <= 1'b0;
          dac_filter_init[ch] <= 1'b0;
        end else begin
          dac_off_prev[ch]    <= dac_off[ch];
          // one-cycle restart pulse as the channel leaves power-down
          dac_filter_init[ch] <= dac_off_prev[ch] & ~dac_off[ch];
        end
      end
    end
  endgenerate

  // hold clears filter history while off; registers are untouched
  assign dac_filter_hold     = dac_off;
  assign dac_chan_power_down = dac_off;
  assign adc_power_down      = adc_disable;
  assign adc_filter_hold     = adc_disable;

  // adc restart pulse on release of the disable bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      adc_off_prev    <= 1'b0;
      adc_filter_init <= 1'b0;
    end else begin
      adc_off_prev    <= adc_disable;
      adc_filter_init <= adc_off_prev & ~adc_disable;
    end
  end

  // ---------------- master-mode ratio selection ----------------
  logic [RATIO_W-1:0] dac_ratio_lut;  // zero for reserved codes
  logic [RATIO_W-1:0] adc_ratio_lut;
  logic [RATIO_W-1:0] dac_ratio;      // last valid dac ratio
  logic [RATIO_W-1:0] adc_ratio;      // last valid adc ratio

  assign dac_ratio_lut =
      (dac_clock_ratio == 3'h0) ? RATIO_128 :
      (dac_clock_ratio == 3'h1) ? RATIO_192 :
      (dac_clock_ratio == 3'h2) ? RATIO_256 :
      (dac_clock_ratio == 3'h3) ? RATIO_384 :
      (dac_clock_ratio == 3'h4) ? RATIO_512 :
      (dac_clock_ratio == 3'h5) ? RATIO_768 : RATIO_NONE;
  // the adc port only knows the four slower ratios
  assign adc_ratio_lut =
      (adc_clock_ratio == 3'h2) ? RATIO_256 :
      (adc_clock_ratio == 3'h3) ? RATIO_384 :
      (adc_clock_ratio == 3'h4) ? RATIO_512 :
      (adc_clock_ratio == 3'h5) ? RATIO_768 : RATIO_NONE;

  // a reserved code leaves the generator on its previous ratio
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dac_ratio <= RATIO_RST;
      adc_ratio <= RATIO_RST;
    end else begin
      if (dac_ratio_lut != RATIO_NONE) dac_ratio <= dac_ratio_lut;
      if (adc_ratio_lut != RATIO_NONE) adc_ratio <= adc_ratio_lut;
    end
  end

  // ---------------- port clock generation and direction ----------------
  logic dac_gen_frame;  // generated dac clocks
  logic dac_gen_bit;
  logic adc_gen_frame;  // generated adc clocks
  logic adc_gen_bit;

  // clk_sys stands in for the converter master clock
  cpc_clock_gen #(.RW(RATIO_W)) u_dac_clk (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .enable      (dac_port_master_select),
    .ratio       (dac_ratio),
    .frame_clock (dac_gen_frame),
    .bit_clock   (dac_gen_bit)
  );

  cpc_clock_gen #(.RW(RATIO_W)) u_adc_clk (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .enable      (adc_port_master_select),
    .ratio       (adc_ratio),
    .frame_clock (adc_gen_frame),
    .bit_clock   (adc_gen_bit)
  );

  // pins driven only in master mode; the gate hides the generator flop lag
  assign dac_frame_clock_out = dac_gen_frame & dac_port_master_select;
  assign dac_bit_clock_out   = dac_gen_bit & dac_port_master_select;
  assign dac_frame_clock_oe  = dac_port_master_select;
  assign dac_bit_clock_oe    = dac_port_master_select;
  assign adc_frame_clock_out = adc_gen_frame & adc_port_master_select;
  assign adc_bit_clock_out   = adc_gen_bit & adc_port_master_select;
  assign adc_frame_clock_oe  = adc_port_master_select;
  assign adc_bit_clock_oe    = adc_port_master_select;

  // clocks seen by the port logic, registered to match both sources
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dac_port_frame <= 1'b0;
      dac_port_bit   <= 1'b0;
      adc_port_frame <= 1'b0;
      adc_port_bit   <= 1'b0;
    end else begin
      dac_port_frame <= dac_port_master_select ? dac_gen_frame
                                               : dac_frame_clock_in;
      dac_port_bit   <= dac_port_master_select ? dac_gen_bit
                                               : dac_bit_clock_in;
      adc_port_frame <= adc_port_master_select ? adc_gen_frame
                                               : adc_frame_clock_in;
      adc_port_bit   <= adc_port_master_select ? adc_gen_bit
                                               : adc_bit_clock_in;
    end
  end

  // ---------------- adc port format and word shaping ----------------
  cpc_wl_e     eff_wl;    // length actually used on the port
  logic [31:0] wl_mask;   // keeps the top eff_wl bits

  // 32-bit right justified is unsupported; fall back to 24 bits
  assign eff_wl  = (adc_wl == WL_32 && adc_fmt == FMT_RIGHT) ? WL_24
                                                             : adc_wl;
  assign wl_mask = (eff_wl == WL_16) ? MASK_16 :
                   (eff_wl == WL_20) ? MASK_20 :
                   (eff_wl == WL_24) ? MASK_24 : MASK_32;
  assign adc_port_format = adc_fmt;
  assign adc_word_length = eff_wl;
  // the polarity bit changes meaning in dsp format
  assign adc_dsp_mode_b   = (adc_fmt == FMT_DSP) & adc_frame_polarity;
  assign adc_frame_invert = (adc_fmt != FMT_DSP) & adc_frame_polarity;

  // left-aligned words: truncation keeps the sign bit on top
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      adc_port_word       <= '0;
      adc_port_word_valid <= 1'b0;
    end else begin
      adc_port_word_valid <= adc_sample_valid & ~adc_disable;
      if (adc_sample_valid) begin
        adc_port_word <= {adc_sample, PAD_ZERO} & wl_mask;
      end
    end
  end

endmodule // cpc_power_if_ctrl
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %0h want %0h", $time, (g), (e)); end end
module testbench
  import cpc_pkg::*;
();
  logic clk_sys, resetn, ctl_clock, ctl_data, ctl_latch, fr_in, bt_in;
  logic [SAMPLE_W-1:0] adc_sample;
  logic adc_sample_valid, clr;
  logic dac_frame_clock_out, dac_frame_clock_oe, dac_bit_clock_out;
  logic dac_bit_clock_oe, adc_frame_clock_out, adc_frame_clock_oe;
  logic adc_bit_clock_out, adc_bit_clock_oe, dac_port_frame, dac_port_bit;
  logic adc_port_frame, adc_port_bit, adc_power_down, adc_filter_hold;
  logic adc_filter_init, reference_power_down, adc_dsp_mode_b;
  logic adc_frame_invert, adc_port_word_valid, ainit_seen;
  logic [2:0] dac_chan_select_a_active, dac_chan_power_down, dac_filter_hold;
  logic [2:0] dac_filter_init, dinit_seen;
  logic [1:0] adc_port_format, adc_word_length;
  logic [31:0] adc_port_word, wexp, rnd = 32'hEB3D0018;
  logic [31:0] word_q[$];  // expected adc words, oldest first
  int n_mismatch = 0, n_checks = 0, eff = 0;
  int rtab[6] = '{RATIO_128, RATIO_192, RATIO_256, RATIO_384, RATIO_512,
                  RATIO_768};
  logic [31:0] mtab[4] = '{MASK_16, MASK_20, MASK_24, MASK_32};

  cpc_host_model i_host (.clk_sys, .ctl_clock, .ctl_data, .ctl_latch,
                         .frame_in(fr_in), .bit_in(bt_in));
  cpc_power_if_ctrl i_dut (.dac_frame_clock_in(fr_in), .dac_bit_clock_in(bt_in),
                           .adc_frame_clock_in(fr_in), .adc_bit_clock_in(bt_in),
                           .*);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // catches one-cycle init pulses and takes each adc word off the queue
  always @(posedge clk_sys) begin
    dinit_seen <= clr ? 3'h0 : dinit_seen | dac_filter_init;
    ainit_seen <= clr ? 1'b0 : ainit_seen | adc_filter_init;
    if (adc_port_word_valid === 1'b1) begin
      wexp = word_q.size() ? word_q.pop_front() : 'x;  // no note: refused
      `CHK(adc_port_word, wexp)
    end
  end

  task automatic arm;  // clear pulse catchers before a write
    @(posedge clk_sys) clr <= 1'b1;
    @(posedge clk_sys) clr <= 1'b0;
  endtask

  task automatic sample(input logic push);
    @(posedge clk_sys);
    rnd = lfsr(rnd);
    adc_sample <= rnd[SAMPLE_W-1:0];
    adc_sample_valid <= 1'b1;
    if (push) word_q.push_back({rnd[SAMPLE_W-1:0], PAD_ZERO} & mtab[eff]);
    @(posedge clk_sys) adc_sample_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // skip the frame in flight and one full frame, then count the next frame in master clocks
  task automatic period(input logic adc, input int want);
    int n, r, len;
    logic p, c;
    n = 0; r = 0; len = 0; p = 1'b1;
    while (r < 3 && n < 4000) begin
      @(posedge clk_sys);
      c = adc ? adc_frame_clock_out : dac_frame_clock_out;
      if (r == 2) len++;
      if (c === 1'b1 && p === 1'b0) r++;
      p = c;
      n++;
    end
    if (n >= 4000) begin
      n_mismatch++;
      report_and_stop;
    end else begin
      `CHK(len, want)
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    resetn = 1'b0; clr = 1'b0; adc_sample = '0; adc_sample_valid = 1'b0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    `CHK({dac_chan_select_a_active, dac_chan_power_down}, 6'h00)
    `CHK({reference_power_down, adc_port_format, adc_word_length}, 5'h00)
    $display("test reset done");
    // every mask code, then the global override
    for (int m = 0; m < 8; m++) begin
      i_host.write(ADDR_CHAN_SELECT_A, 9'(m << CHAN_SELECT_A_LSB));
      `CHK(dac_chan_select_a_active, 3'(m))
    end
    i_host.write(ADDR_CHAN_SELECT_A, 9'h000);
    i_host.write(ADDR_GLOBAL, 9'h002);
    `CHK(dac_chan_select_a_active, 3'h7)
    $display("test deemphasis done");
    i_host.write(ADDR_POWER, 9'h084);
    `CHK(dac_chan_power_down, 3'h2)
    i_host.write(ADDR_GLOBAL, 9'h006);
    `CHK({dac_chan_power_down, dac_filter_hold}, 6'h3F)
    arm;
    i_host.write(ADDR_GLOBAL, 9'h002);
    `CHK({dac_chan_power_down, dinit_seen}, 6'h15)
    arm;
    i_host.write(ADDR_POWER, 9'h080);
    `CHK(dinit_seen, 3'h2)
    // converters first, references last
    i_host.write(ADDR_POWER, 9'h08F);
    sample(1'b0);
    i_host.write(ADDR_POWER, 9'h09F);
    `CHK({adc_power_down, adc_filter_hold, reference_power_down}, 3'h7)
    arm;
    i_host.write(ADDR_POWER, 9'h080);
    `CHK({reference_power_down, adc_power_down, ainit_seen}, 3'h1)
    $display("test power done");
    // every dac ratio, then a reserved code
    for (int c = 0; c < 7; c++) begin
      i_host.write(ADDR_POWER, 9'((c << DAC_RATE_LSB) | 9'h020));
      `CHK(dac_frame_clock_oe, 1'b1)
      period(1'b0, rtab[c > 5 ? 5 : c]);
    end
    i_host.write(ADDR_POWER, 9'h080);
    `CHK({dac_frame_clock_oe, dac_bit_clock_oe}, 2'h0)
    $display("test dac master done");
    // every format and length with samples through the port
    for (int i = 0; i < 16; i++) begin
      i_host.write(ADDR_ADC_PORT, 9'(i) | 9'h040);
      eff = (i == 12) ? 2 : i >> 2;
      `CHK({adc_word_length, adc_port_format}, 4'(i == 12 ? 8 : i))
      sample(1'b1);
      sample(1'b1);
    end
    $display("test adc format done");
    i_host.write(ADDR_ADC_PORT, 9'h070);
    `CHK({adc_frame_clock_oe, adc_bit_clock_oe}, 2'h3)
    period(1'b1, RATIO_384);
    i_host.write(ADDR_ADC_PORT, 9'h0F0);
    period(1'b1, RATIO_384);
    i_host.write(ADDR_ADC_CTRL, 9'h010);
    i_host.write(ADDR_ADC_PORT, 9'h043);
    `CHK({adc_dsp_mode_b, adc_frame_invert}, 2'h2)
    i_host.write(ADDR_ADC_PORT, 9'h040);
    `CHK({adc_dsp_mode_b, adc_frame_invert}, 2'h1)
    `CHK(word_q.size(), 0)
    `CHK({dac_port_bit, adc_port_bit}, {2{~bt_in}})
    `CHK(adc_port_frame, dac_port_frame)
    $display("test adc master done");
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
